/* core/phb_defines.svh */
`ifndef PHB_DEFINES_SVH
`define PHB_DEFINES_SVH

`define PHB_CMD_IO_RD     4'h2
`define PHB_CMD_IO_WR     4'h3
`define PHB_CMD_MEM_RD    4'h6
`define PHB_CMD_MEM_WR    4'h7
`define PHB_CMD_CFG_RD    4'ha
`define PHB_CMD_CFG_WR    4'hb

`define PHB_MODE_PCI      2'h0
`define PHB_MODE_VL       2'h1
`define PHB_MODE_ISA16    2'h2

`define PHB_CFG_WORDS     16
`define PHB_MEM_WORDS     8
`define PHB_CFG_IDX_CMD   4'h1
`define PHB_CFG_IDX_BAR   4'h4
`define PHB_CMD_MEM_EN    1
`define PHB_BAR_LSB       5
`define PHB_DEVSEL_WAIT   3'h5
`define PHB_SYNC_W        48

`endif

/* core/phb_pkg.sv */
package phb_pkg;
	typedef enum logic [1:0] {MST_IDLE, MST_REQ, MST_DATA, MST_END} phb_mst_type;
	typedef enum logic [2:0] {TGT_IDLE, TGT_DATA, TGT_STOP, TGT_END, TGT_ADDR} phb_tgt_type;
endpackage

/* core/phb_sync.sv */
`timescale 1ns/1ps
module phb_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge mclk_in) begin
		meta_r <= d_in;
		q_out  <= meta_r;
	end
endmodule

/* core/phb_bus_if.sv */
`timescale 1ns/1ps
`include "phb_defines.svh"
module phb_bus_if #(
	parameter logic [31:0] ID_WORD = 32'h0001_0001 // Arbitrary identity value
) (
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	input  wire logic        pci_clk_in,
	input  wire logic        pci_rst_n_in,
	input  wire logic [31:0] ad_in,
	input  wire logic [3:0]  cbe_n_in,
	input  wire logic        frame_n_in,
	input  wire logic        irdy_n_in,
	input  wire logic        trdy_n_in,
	input  wire logic        devsel_n_in,
	input  wire logic        stop_n_in,
	input  wire logic        lock_n_in,
	input  wire logic        idsel_in,
	input  wire logic        gnt_n_in,
	input  wire logic [1:0]  cfg_strap_in,
	input  wire logic        vretrace_in,
	input  wire logic        retrace_irq_en_in,
	input  wire logic        irq_clear_in,
	input  wire logic        rom_read_req_in,
	input  wire logic        isa_low_sel_in,
	input  wire logic        isa_high_sel_in,
	input  wire logic        mst_req_in,
	input  wire logic [31:0] mst_addr_in,
	input  wire logic [3:0]  mst_cmd_in,
	input  wire logic [31:0] mst_wdata_in,
	input  wire logic [3:0]  mst_be_n_in,
	output logic      [31:0] ad_out,
	output logic             ad_oe_out,
	output logic      [3:0]  cbe_n_out,
	output logic             cbe_oe_out,
	output logic             par_out,
	output logic             par_oe_out,
	output logic             frame_n_out,
	output logic             frame_oe_out,
	output logic             irdy_n_out,
	output logic             irdy_oe_out,
	output logic             trdy_n_out,
	output logic             trdy_oe_out,
	output logic             devsel_n_out,
	output logic             devsel_oe_out,
	output logic             stop_n_out,
	output logic             stop_oe_out,
	output logic             req_n_out,
	output logic             crt_retrace_irq_n_out,
	output logic             crt_retrace_irq_oe_out,
	output logic             rom_buffer_output_enable_n_out,
	output logic             mst_busy_out,
	output logic             mst_done_out,
	output logic             mst_abort_out,
	output logic             mst_retry_out,
	output logic      [31:0] mst_rdata_out
);
	import phb_pkg::*;

	logic [`PHB_SYNC_W-1:0] sync_q;
	logic [31:0] ad_s;
	logic [3:0]  cbe_s, mcmd_r, mbe_r;
	logic [1:0]  strap_s, mode_r;
	logic        frame_s, irdy_s, trdy_s, devsel_s, stop_s, lock_s, idsel_s, gnt_s;
	logic        rst_n_s, clk_s, clk_d_r, act, rst_int, frame_d_r, lock_r;
	logic        vr_d_r, twr_r, tcfg_r, tad_oe_r, mad_oe_r;
	logic [31:0] tad_r, mad_r, maddr_r, mwdata_r, rdata;
	logic [3:0]  tidx_r;
	logic [2:0]  wait_r;
	logic        hit_cfg, hit_mem, is_rd, is_wr;
	logic [31:0] cfg_mem [0:`PHB_CFG_WORDS-1];
	logic [31:0] data_mem [0:`PHB_MEM_WORDS-1];
	phb_mst_type mst_st;
	phb_tgt_type tgt_st;

	phb_sync #(.W(`PHB_SYNC_W)) u_sync (
		.mclk_in (mclk_in),
		.d_in    ({ad_in, cbe_n_in, frame_n_in, irdy_n_in, trdy_n_in, devsel_n_in,
			stop_n_in, lock_n_in, idsel_in, gnt_n_in, pci_rst_n_in, pci_clk_in,
			cfg_strap_in}),
		.q_out   (sync_q)
	);
	assign {ad_s, cbe_s, frame_s, irdy_s, trdy_s, devsel_s, stop_s, lock_s, idsel_s,
		gnt_s, rst_n_s, clk_s, strap_s} = sync_q;

	// Bus clock only sampled; bus steps run on its detected rising edge, except a master request, taken with req_n_out on any fast clock
	assign act     = clk_s & ~clk_d_r;
	assign rst_int = srst_in | ~rst_n_s;

	always_ff @(posedge mclk_in) begin
		clk_d_r <= clk_s;
	end

	// Straps follow the pins while reset is held and freeze at its release
	always_ff @(posedge mclk_in) begin
		if (rst_int) begin
			mode_r <= strap_s;
		end
	end

	// Address decode of a fresh address phase
	assign is_rd   = (cbe_s == `PHB_CMD_MEM_RD) || (cbe_s == `PHB_CMD_CFG_RD);
	assign is_wr   = (cbe_s == `PHB_CMD_MEM_WR) || (cbe_s == `PHB_CMD_CFG_WR);
	assign hit_cfg = idsel_s && ad_s[1:0] == 2'h0 &&
		(cbe_s == `PHB_CMD_CFG_RD || cbe_s == `PHB_CMD_CFG_WR);
	assign hit_mem = cfg_mem[`PHB_CFG_IDX_CMD][`PHB_CMD_MEM_EN] &&
		(cbe_s == `PHB_CMD_MEM_RD || cbe_s == `PHB_CMD_MEM_WR) &&
		ad_s[31:`PHB_BAR_LSB] == cfg_mem[`PHB_CFG_IDX_BAR][31:`PHB_BAR_LSB];
	assign rdata   = tcfg_r ? ((tidx_r == 4'h0) ? ID_WORD : cfg_mem[tidx_r])
		: data_mem[tidx_r[2:0]];

	// Target side
	always_ff @(posedge mclk_in) begin
		if (rst_int) begin
			tgt_st        <= TGT_IDLE;
			trdy_oe_out   <= 1'b0;
			devsel_oe_out <= 1'b0;
			stop_oe_out   <= 1'b0;
			tad_oe_r      <= 1'b0;
			trdy_n_out    <= 1'b1;
			devsel_n_out  <= 1'b1;
			stop_n_out    <= 1'b1;
			frame_d_r     <= 1'b1;
			lock_r        <= 1'b0;
			twr_r         <= 1'b0;
			tcfg_r        <= 1'b0;
			tidx_r        <= 4'h0;
			tad_r         <= 32'h0;
			for (int i = 0; i < `PHB_CFG_WORDS; i++) begin
				cfg_mem[i] <= 32'h0;
			end
		end else if (act) begin
			frame_d_r <= frame_s;
			// Locked sequence ends once FRAME and LOCK are both idle
			if (frame_s && lock_s) begin
				lock_r <= 1'b0;
			end
			unique case (tgt_st)
				TGT_IDLE: begin
					// Own master cycles never decode against this target
					if (!frame_s && frame_d_r && mst_st == MST_IDLE && (hit_cfg || hit_mem)) begin
						devsel_n_out  <= 1'b0;
						devsel_oe_out <= 1'b1;
						trdy_n_out    <= 1'b1;
						trdy_oe_out   <= 1'b1;
						stop_oe_out   <= 1'b1;
						tcfg_r        <= hit_cfg;
						twr_r         <= is_wr;
						tidx_r        <= hit_cfg ? ad_s[5:2] : {1'b0, ad_s[4:2]};
						if (lock_r && lock_s) begin
							stop_n_out <= 1'b0;
							tgt_st     <= TGT_STOP;
						end else begin
							stop_n_out <= 1'b1;
							tgt_st     <= (is_rd || is_wr) ? TGT_DATA : TGT_STOP;
						end
					end
				end
				TGT_DATA: begin
					if (trdy_n_out) begin
						if (twr_r) begin
							trdy_n_out <= 1'b0;
						end else if (!tad_oe_r) begin
							tad_r    <= rdata;
							tad_oe_r <= 1'b1;
						end else begin
							trdy_n_out <= 1'b0;
						end
					end else if (!irdy_s) begin
						if (twr_r) begin
							for (int b = 0; b < 4; b++) begin
								if (!cbe_s[b]) begin
									if (tcfg_r && tidx_r != 4'h0) begin
										cfg_mem[tidx_r][8*b +: 8] <= ad_s[8*b +: 8];
									end
								end
							end
						end
						if (!lock_s) begin
							lock_r <= 1'b1;
						end
						trdy_n_out <= 1'b1;
						tad_oe_r   <= 1'b0;
						if (frame_s) begin
							devsel_n_out <= 1'b1;
							tgt_st       <= TGT_END;
						end else begin
							// Single-phase target: burst gets a disconnect
							stop_n_out <= 1'b0;
							tgt_st     <= TGT_STOP;
						end
					end
				end
				TGT_STOP: begin
					trdy_n_out <= 1'b1;
					if (frame_s) begin
						devsel_n_out <= 1'b1;
						stop_n_out   <= 1'b1;
						tgt_st       <= TGT_END;
					end
				end
				TGT_END: begin
					trdy_oe_out   <= 1'b0;
					devsel_oe_out <= 1'b0;
					stop_oe_out   <= 1'b0;
					tgt_st        <= TGT_IDLE;
				end
				default: tgt_st <= TGT_IDLE;
			endcase
		end
	end

	// Memory window holds no reset value, only software data
	always_ff @(posedge mclk_in) begin
		if (!rst_int && act && tgt_st == TGT_DATA && twr_r && !tcfg_r && !trdy_n_out && !irdy_s) begin
			for (int b = 0; b < 4; b++) begin
				if (!cbe_s[b]) begin
					data_mem[tidx_r[2:0]][8*b +: 8] <= ad_s[8*b +: 8];
				end
			end
		end
	end

	// Master side: one data phase per request
	always_ff @(posedge mclk_in) begin
		mst_done_out <= 1'b0;
		if (rst_int) begin
			mst_st        <= MST_IDLE;
			req_n_out     <= 1'b1;
			frame_n_out   <= 1'b1;
			frame_oe_out  <= 1'b0;
			irdy_n_out    <= 1'b1;
			irdy_oe_out   <= 1'b0;
			cbe_n_out     <= 4'hf;
			cbe_oe_out    <= 1'b0;
			mad_oe_r      <= 1'b0;
			mad_r         <= 32'h0;
			maddr_r       <= 32'h0;
			mwdata_r      <= 32'h0;
			mcmd_r        <= 4'h0;
			mbe_r         <= 4'hf;
			wait_r        <= 3'h0;
			mst_abort_out <= 1'b0;
			mst_retry_out <= 1'b0;
			mst_rdata_out <= 32'h0;
			mst_busy_out  <= 1'b0;
		end else if (mst_st == MST_IDLE) begin
			if (mst_req_in) begin
				maddr_r   <= mst_addr_in;
				mcmd_r    <= mst_cmd_in;
				mwdata_r  <= mst_wdata_in;
				mbe_r     <= mst_be_n_in;
				req_n_out <= 1'b0;
				mst_busy_out <= 1'b1;
				mst_st    <= MST_REQ;
			end
		end else if (act) begin
			unique case (mst_st)
				MST_REQ: begin
					if (!gnt_s && frame_s && irdy_s && tgt_st == TGT_IDLE) begin
						frame_n_out  <= 1'b0;
						frame_oe_out <= 1'b1;
						mad_r        <= maddr_r;
						mad_oe_r     <= 1'b1;
						cbe_n_out    <= mcmd_r;
						cbe_oe_out   <= 1'b1;
						wait_r       <= 3'h0;
						mst_st       <= MST_DATA;
					end
				end
				MST_DATA: begin
					if (irdy_n_out) begin
						// Last phase: FRAME rises as IRDY falls
						frame_n_out <= 1'b1;
						irdy_n_out  <= 1'b0;
						irdy_oe_out <= 1'b1;
						req_n_out   <= 1'b1;
						cbe_n_out   <= mbe_r;
						mad_r       <= mwdata_r;
						mad_oe_r    <= mcmd_r[0];
					end else if (!trdy_s || !stop_s || (devsel_s && wait_r == `PHB_DEVSEL_WAIT)) begin
						mst_rdata_out <= ad_s;
						mst_retry_out <= trdy_s && !stop_s;
						mst_abort_out <= devsel_s && trdy_s && stop_s;
						mst_done_out  <= 1'b1;
						irdy_n_out    <= 1'b1;
						frame_oe_out  <= 1'b0;
						cbe_oe_out    <= 1'b0;
						mad_oe_r      <= 1'b0;
						mst_st        <= MST_END;
					end else if (devsel_s) begin
						wait_r <= wait_r + 3'h1;
					end
				end
				MST_END: begin
					irdy_oe_out  <= 1'b0;
					mst_busy_out <= 1'b0;
					mst_st       <= MST_IDLE;
				end
				default: mst_st <= MST_IDLE;
			endcase
		end
	end

	// AD merge and parity of what was driven in the previous bus clock
	always_ff @(posedge mclk_in) begin
		if (rst_int) begin
			ad_out     <= 32'h0;
			ad_oe_out  <= 1'b0;
			par_out    <= 1'b0;
			par_oe_out <= 1'b0;
		end else begin
			ad_out    <= mad_oe_r ? mad_r : tad_r;
			ad_oe_out <= mad_oe_r | tad_oe_r;
			if (act) begin
				par_out    <= ^ad_out ^ (cbe_oe_out ? ^cbe_n_out : ^cbe_s);
				par_oe_out <= ad_oe_out;
			end
		end
	end

	// Open-drain interrupt: only ever pulls low; set beats a same-cycle clear
	always_ff @(posedge mclk_in) begin
		vr_d_r <= vretrace_in;
		if (rst_int) begin
			crt_retrace_irq_oe_out <= 1'b0;
			crt_retrace_irq_n_out  <= 1'b1;
		end else if (vretrace_in && !vr_d_r && retrace_irq_en_in) begin
			crt_retrace_irq_oe_out <= 1'b1;
			crt_retrace_irq_n_out  <= 1'b0;
		end else if (irq_clear_in) begin
			crt_retrace_irq_oe_out <= 1'b0;
			crt_retrace_irq_n_out  <= 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_int) begin
			rom_buffer_output_enable_n_out <= 1'b1;
		end else begin
			unique case (mode_r)
				`PHB_MODE_PCI:   rom_buffer_output_enable_n_out <= ~rom_read_req_in;
				`PHB_MODE_VL:    rom_buffer_output_enable_n_out <= ~isa_low_sel_in;
				`PHB_MODE_ISA16: rom_buffer_output_enable_n_out <= ~isa_high_sel_in;
				default:         rom_buffer_output_enable_n_out <= 1'b1;
			endcase
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);

	a_irq_enable_gate: assert property ($rose(crt_retrace_irq_oe_out) |-> $past(retrace_irq_en_in))
		else $error("interrupt raised while disabled");
	a_irq_retrace_set: assert property ((vretrace_in && !vr_d_r && retrace_irq_en_in) |=> !crt_retrace_irq_n_out)
		else $error("retrace did not raise interrupt");
	a_reset_fsm_idle: assert property (!rst_n_s |=> tgt_st == TGT_IDLE && mst_st == MST_IDLE)
		else $error("state machine not idle in reset");
	a_reset_pins_free: assert property (!rst_n_s |=> !(ad_oe_out | trdy_oe_out | frame_oe_out | irdy_oe_out))
		else $error("bus driven during reset");
	a_strap_latch: assert property (!rst_n_s ##1 rst_n_s |=> mode_r == $past(strap_s, 2))
		else $error("strap not latched");
	a_parity_even: assert property ((act && ad_oe_out && cbe_oe_out) |=> par_oe_out && ^{$past(ad_out), $past(cbe_n_out), par_out} == 1'b0)
		else $error("parity not even");
	a_grant_first: assert property ($rose(frame_oe_out) |-> !$past(gnt_s) && !$past(req_n_out))
		else $error("frame without grant");
	a_cfg_idsel: assert property ($fell(devsel_n_out) && tcfg_r |-> $past(idsel_s))
		else $error("config claim without idsel");
	a_trdy_claimed: assert property (trdy_oe_out && !trdy_n_out |-> !devsel_n_out)
		else $error("trdy without devsel");
	a_read_data_valid: assert property (!trdy_n_out && !twr_r |-> ##1 ad_oe_out)
		else $error("read trdy without data");
	a_release_high: assert property ($fell(trdy_oe_out) |-> $past(trdy_n_out) && $past(devsel_n_out) && $past(stop_n_out))
		else $error("released while low");
	a_stop_ends: assert property ((mst_st == MST_DATA && !irdy_n_out && act && trdy_s && !stop_s) |=> mst_st == MST_END && irdy_n_out)
		else $error("master ignored stop");
endmodule

/* test/phb_host_model.sv */
`timescale 1ns/1ps
module phb_host_model (
	input  wire logic        mclk_in,
	input  wire logic        pci_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        req_n_in,
	input  wire logic        frame_n_in,
	input  wire logic        irdy_n_in,
	input  wire logic [3:0]  cbe_n_in,
	input  wire logic [1:0]  mode_in,
	input  wire logic [31:0] rdata_in,
	output logic             gnt_n_out,
	output logic             t_oe_out,
	output logic             trdy_n_out,
	output logic             devsel_n_out,
	output logic             stop_n_out,
	output logic             ad_oe_out,
	output logic      [31:0] ad_out
);
	logic       clk_r;
	logic       fr_r;
	logic       rd_r;
	logic [1:0] st_r;
	wire        pe_w = pci_clk_in & ~clk_r;

	// Edges found on the fast clock so our changes land after the sampling edge
	always_ff @(posedge mclk_in) begin
		clk_r <= pci_clk_in;
		if (pe_w) begin
			fr_r      <= frame_n_in;
			gnt_n_out <= req_n_in | ~rst_n_in;
		end
	end

	// Mode 0 answers, mode 1 asks for a retry, mode 2 never claims
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			st_r      <= 2'h0;
			t_oe_out  <= 1'b0;
			ad_oe_out <= 1'b0;
		end else if (pe_w) begin
			case (st_r)
			2'h0: if (fr_r && !frame_n_in && !gnt_n_out && mode_in != 2'h2) begin
				st_r         <= 2'h1;
				rd_r         <= ~cbe_n_in[0];
				t_oe_out     <= 1'b1;
				devsel_n_out <= 1'b0;
				trdy_n_out   <= 1'b1;
				stop_n_out   <= 1'b1;
			end
			2'h1: begin
				st_r       <= 2'h2;
				trdy_n_out <= mode_in[0];
				stop_n_out <= ~mode_in[0];
				ad_oe_out  <= rd_r & ~mode_in[0];
				ad_out     <= rdata_in;
			end
			2'h2: if (!irdy_n_in) begin
				st_r         <= 2'h3;
				trdy_n_out   <= 1'b1;
				devsel_n_out <= 1'b1;
				stop_n_out   <= 1'b1;
				ad_oe_out    <= 1'b0;
			end
			default: begin
				st_r     <= 2'h0;
				t_oe_out <= 1'b0;
			end
			endcase
		end
	end
endmodule

/* test/pci_host_bus_interface_bench.sv */
`timescale 1ns/1ps
`include "phb_defines.svh"
module pci_host_bus_interface_bench;
	localparam logic [31:0] IDW = 32'h5a5a_0c3e; // Arbitrary identity value
	logic        mclk = 0, srst = 1, pci_clk = 0, prst_n = 0, pc_r = 0, idsel = 0, lock_n = 1;
	logic        h_oe = 0, h_frame = 1, h_irdy = 1, h_ad_oe = 0, h_cbe_oe = 0, lv = 0, lp = 0;
	logic        fp_oe = 0, vret = 0, irq_en = 0, irq_clr = 0, mreq = 0;
	logic [2:0]  sel = 0;
	logic [1:0]  strap = 0, mode = 0;
	logic [3:0]  h_cbe = 0, m_cmd = 0, m_be = 0;
	logic [31:0] h_ad = 0, pat = 0, m_addr = 0, m_wd = 0, p_rd = 0, base;
	logic [31:0] mem [8];
	integer      seed = 32'hcc91;
	int          fails = 0, n_tests = 0;
	logic        ad_oe, cbe_oe, par_o, par_oe, fr_o, fr_oe, ir_o, ir_oe, tr_o, tr_oe, dv_o;
	logic        dv_oe, st_o, st_oe, req_n, irq_n, irq_oe, rom_n, done, abort, retry;
	logic        gnt_n, p_oe, p_trdy, p_dv, p_st, p_ad_oe;
	logic        busy, stopped = 0, lk = 1;
	logic [3:0]  cbe_o;
	logic [31:0] ad_o, rdata, p_ad;
	// Undriven lines without pull-up toggle so a stale value never passes
	wire  [31:0] ad = ad_oe ? ad_o : p_ad_oe ? p_ad : h_ad_oe ? h_ad : pat;
	wire  [3:0]  cbe = cbe_oe ? cbe_o : h_cbe_oe ? h_cbe : pat[3:0];
	wire         par = par_oe ? par_o : fp_oe ? lp : pat[4];
	wire         frame = fr_oe ? fr_o : h_oe ? h_frame : 1'b1;
	wire         irdy = ir_oe ? ir_o : h_oe ? h_irdy : 1'b1;
	wire         trdy = tr_oe ? tr_o : p_oe ? p_trdy : 1'b1;
	wire         devsel = dv_oe ? dv_o : p_oe ? p_dv : 1'b1;
	wire         stop = st_oe ? st_o : p_oe ? p_st : 1'b1;
	wire         pe = pci_clk & ~pc_r;

	phb_bus_if #(.ID_WORD(IDW)) uut (
		.mclk_in(mclk), .srst_in(srst), .pci_clk_in(pci_clk), .pci_rst_n_in(prst_n),
		.ad_in(ad), .cbe_n_in(cbe), .frame_n_in(frame), .irdy_n_in(irdy), .trdy_n_in(trdy),
		.devsel_n_in(devsel), .stop_n_in(stop), .lock_n_in(lock_n), .idsel_in(idsel),
		.gnt_n_in(gnt_n), .cfg_strap_in(strap), .vretrace_in(vret), .retrace_irq_en_in(irq_en),
		.irq_clear_in(irq_clr), .rom_read_req_in(sel[0]), .isa_low_sel_in(sel[1]),
		.isa_high_sel_in(sel[2]), .mst_req_in(mreq), .mst_addr_in(m_addr), .mst_cmd_in(m_cmd),
		.mst_wdata_in(m_wd), .mst_be_n_in(m_be), .ad_out(ad_o), .ad_oe_out(ad_oe),
		.cbe_n_out(cbe_o), .cbe_oe_out(cbe_oe), .par_out(par_o), .par_oe_out(par_oe),
		.frame_n_out(fr_o), .frame_oe_out(fr_oe), .irdy_n_out(ir_o), .irdy_oe_out(ir_oe),
		.trdy_n_out(tr_o), .trdy_oe_out(tr_oe), .devsel_n_out(dv_o), .devsel_oe_out(dv_oe),
		.stop_n_out(st_o), .stop_oe_out(st_oe), .req_n_out(req_n),
		.crt_retrace_irq_n_out(irq_n), .crt_retrace_irq_oe_out(irq_oe),
		.rom_buffer_output_enable_n_out(rom_n), .mst_busy_out(busy), .mst_done_out(done),
		.mst_abort_out(abort), .mst_retry_out(retry), .mst_rdata_out(rdata));

	phb_host_model far (
		.mclk_in(mclk), .pci_clk_in(pci_clk), .rst_n_in(prst_n), .req_n_in(req_n),
		.frame_n_in(frame), .irdy_n_in(irdy), .cbe_n_in(cbe), .mode_in(mode), .rdata_in(p_rd),
		.gnt_n_out(gnt_n), .t_oe_out(p_oe), .trdy_n_out(p_trdy), .devsel_n_out(p_dv),
		.stop_n_out(p_st), .ad_oe_out(p_ad_oe), .ad_out(p_ad));

	always #10 mclk = ~mclk;
	always #80 pci_clk = ~pci_clk;

	// Far side drives parity for what it drove; device parity checked a clock late
	always @(posedge mclk) begin
		pc_r <= pci_clk;
		pat  <= ~pat;
		if (pe) begin
			lv    <= (ad_oe | p_ad_oe | h_ad_oe) & (cbe_oe | h_cbe_oe);
			lp    <= ^{ad, cbe};
			fp_oe <= p_ad_oe | h_ad_oe;
			if (lv && par_oe)
				chk(par_o, lp);
		end
	end

	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
		end
	endtask

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic tmo;
		fails++;
		$display("unexpected at %0t: wait ran out", $time);
		complete_run();
	endtask

	task automatic bclk;
		int k;
		for (k = 0; k < 9; k++) begin
			@(posedge mclk);
			if (pe)
				return;
		end
		tmo();
	endtask

	function automatic logic [31:0] mrg(input logic [31:0] o, n, input logic [3:0] be);
		int b;
		for (b = 0; b < 4; b++)
			if (!be[b])
				o[8*b +: 8] = n[8*b +: 8];
		return o;
	endfunction

	task automatic rst(input logic [1:0] m);
		srst   <= 1'b1;
		prst_n <= 1'b0;
		strap  <= m;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({ad_oe, cbe_oe, par_oe, fr_oe, ir_oe, tr_oe, dv_oe, st_oe, irq_oe}, 0);
		chk({req_n, rom_n, done, busy}, 4'b1100);
		prst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		strap <= 2'h3;
	endtask

	task automatic host(input logic [3:0] c, input logic [31:0] a, w, input logic [3:0] be,
		input logic s, output logic [31:0] r, output logic hit);
		int k;
		hit = 1'b0;
		r   = 32'h0;
		bclk();
		h_oe     <= 1'b1;
		h_frame  <= 1'b0;
		h_ad_oe  <= 1'b1;
		h_ad     <= a;
		h_cbe_oe <= 1'b1;
		h_cbe    <= c;
		idsel    <= s;
		lock_n   <= lk;
		bclk();
		h_frame <= 1'b1;
		h_irdy  <= 1'b0;
		h_cbe   <= be;
		h_ad    <= w;
		h_ad_oe <= c[0];
		for (k = 0; k < 8; k++) begin
			bclk();
			hit = hit | ~devsel;
			if (trdy === 1'b0 || stop === 1'b0)
				break;
		end
		stopped = (stop === 1'b0);
		if (hit && !stopped) begin
			chk({trdy, ad_oe}, {1'b0, ~c[0]});
			r = ad;
		end
		h_irdy   <= 1'b1;
		h_ad_oe  <= 1'b0;
		h_cbe_oe <= 1'b0;
		idsel    <= 1'b0;
		bclk();
		if (hit)
			chk({tr_oe, tr_o, dv_o, st_o}, 4'hf);
		h_oe <= 1'b0;
		bclk();
		chk({tr_oe, dv_oe, st_oe}, 3'h0);
	endtask

	task automatic mst(input logic [1:0] m);
		int k;
		mode   <= m;
		m_cmd  <= ($random(seed) & 1) ? `PHB_CMD_MEM_WR : `PHB_CMD_MEM_RD;
		m_addr <= $random(seed);
		m_wd   <= $random(seed);
		m_be   <= 4'($random(seed));
		p_rd   <= $random(seed);
		mreq   <= 1'b1;
		@(posedge mclk);
		mreq <= 1'b0;
		for (k = 0; k < 8 && req_n !== 1'b0; k++)
			@(posedge mclk);
		chk({req_n, busy}, 2'b01);
		for (k = 0; k < 12 && frame !== 1'b0; k++)
			bclk();
		chk({frame, gnt_n, ad, cbe}, {2'b00, m_addr, m_cmd});
		bclk();
		chk({frame, irdy, cbe_oe, cbe}, {3'b101, m_be});
		if (m_cmd[0])
			chk(ad, m_wd);
		for (k = 0; k < 80 && done !== 1'b1; k++)
			@(posedge mclk);
		chk({done, retry, abort}, {1'b1, m == 2'h1, m == 2'h2});
		if (m == 2'h0 && !m_cmd[0])
			chk(rdata, p_rd);
		repeat (3) bclk();
		chk({fr_oe, ir_oe, cbe_oe, ad_oe, busy}, 0);
	endtask

	initial begin
		logic [31:0] r, d;
		logic [3:0]  be;
		logic [2:0]  w;
		logic        hit;
		int          i;
		rst(2'h0);
		host(`PHB_CMD_CFG_RD, 32'h0, 32'h0, 4'h0, 1'b1, r, hit);
		chk({hit, r}, {1'b1, IDW});
		host(`PHB_CMD_CFG_WR, 32'h4, 32'h2, 4'h0, 1'b0, r, hit);
		chk(hit, 0);
		base = $random(seed) & 32'hffff_ffe0;
		host(`PHB_CMD_CFG_WR, 32'h4, 32'h2, 4'h0, 1'b1, r, hit);
		host(`PHB_CMD_CFG_WR, 32'h10, base, 4'h0, 1'b1, r, hit);
		chk(hit, 1);
		for (i = 0; i < 8; i++) begin
			mem[i] = $random(seed);
			host(`PHB_CMD_MEM_WR, base + 32'(4 * i), mem[i], 4'h0, 1'b0, r, hit);
		end
		for (i = 0; i < 12; i++) begin
			w  = 3'($random(seed));
			d  = $random(seed);
			be = 4'($random(seed));
			host(`PHB_CMD_MEM_WR, base + {w, 2'b00}, d, be, 1'b0, r, hit);
			mem[w] = mrg(mem[w], d, be);
			host(`PHB_CMD_MEM_RD, base + {w, 2'b00}, 32'h0, 4'h0, 1'b0, r, hit);
			chk({hit, stopped, r}, {2'b10, mem[w]});
		end
		// Locked write; an access that drops the lock while still held is retried
		d  = $random(seed);
		lk = 1'b0;
		host(`PHB_CMD_MEM_WR, base, d, 4'h0, 1'b0, r, hit);
		mem[0] = d;
		lk = 1'b1;
		host(`PHB_CMD_MEM_RD, base, 32'h0, 4'h0, 1'b0, r, hit);
		chk({hit, stopped}, 2'b11);
		host(`PHB_CMD_MEM_RD, base, 32'h0, 4'h0, 1'b0, r, hit);
		chk({hit, stopped, r}, {2'b10, mem[0]});
		host(`PHB_CMD_MEM_RD, base + 32'h20, 32'h0, 4'h0, 1'b0, r, hit);
		chk(hit, 0);
		for (i = 0; i < 6; i++)
			mst(2'(i % 3));
		for (i = 0; i < 2; i++) begin
			irq_en <= i[0];
			vret   <= 1'b1;
			repeat (4) @(posedge mclk);
			chk(irq_oe & ~irq_n, i[0]);
			vret    <= 1'b0;
			irq_clr <= 1'b1;
			@(posedge mclk);
			irq_clr <= 1'b0;
			repeat (3) @(posedge mclk);
			chk(irq_oe, 0);
		end
		// Straps changed after release must not alter the mode
		for (i = 0; i < 3; i++) begin
			rst(2'(i));
			chk(rom_n, 1);
			sel[i] <= 1'b1;
			@(posedge mclk);
			#1 chk(rom_n, 0);
			@(posedge mclk);
			sel <= 3'h0;
		end
		host(`PHB_CMD_MEM_RD, base, 32'h0, 4'h0, 1'b0, r, hit);
		chk(hit, 0);
		complete_run();
	end
endmodule
